// ==== include/qflag_defs.svh ====
// register map, field positions, reset values and counts of the flag logic
`ifndef QFLAG_DEFS_SVH
`define QFLAG_DEFS_SVH

`define NUM_QUEUES     16
`define BUS_QUEUES     8

// word offsets inside the 256-byte window
`define REG_CTRL       8'h00
`define REG_STATUS     8'h04
`define GRP_CTRL       2'h0
`define GRP_AF_OFF     2'h1
`define GRP_AE_OFF     2'h2
`define GRP_OCC        2'h3

`define CTRL_MODE_MSB  2
`define CTRL_RESET     3'h0
`define STAT_DFLT_BIT  16
`define STAT_RUN_BIT   17

// default offsets picked by the strap at master reset
`define DEF_OFF_LO     16'h0008
`define DEF_OFF_HI     16'h0080

// occupancy is kept in quarter words (9-bit units)
`define STEP_36        3'h4
`define STEP_18        3'h2
`define STEP_9         3'h1
`define QUARTER_SHIFT  2

`endif

// ==== include/qflag_pkg.sv ====
// types shared by the queue flag logic
package qflag_pkg;

   typedef logic [3:0] qid_t;

   typedef enum logic [2:0] {
      BW_36_36 = 3'h0,
      BW_36_18 = 3'h1,
      BW_36_9  = 3'h2,
      BW_18_36 = 3'h3,
      BW_9_36  = 3'h4
   } bw_mode_e;

   typedef enum logic [3:0] {
      INIT_SYNC0 = 4'h1,
      INIT_SYNC1 = 4'h2,
      INIT_LOAD  = 4'h4,
      INIT_RUN   = 4'h8
   } init_e;

   typedef struct packed {
      logic load;
      qid_t queue;
      logic en;
      logic tx_start_marker;
      logic tx_end_marker;
   } wr_port_s;

   typedef struct packed {
      logic load;
      qid_t read_queue_select_bus;
      logic en;
      logic rx_start_marker;
   } rd_port_s;

endpackage

// ==== logic/queue_flag_logic.sv ====
// per-queue full, almost-full, almost-empty and packet-ready flag logic
`timescale 1ns/10ps
`include "qflag_defs.svh"

// Operation
// R01: full flag drops low straight from the filling write edge.
// R02: full flag releases high the cycle after a read frees space.
// R03: 36/36 with both ports on queue: almost-full after D+1-m writes.
// R04: almost-full after D-m writes: write-only 36/36, 36/18, 36/9.
// R05: narrow input: almost-full after (D+1-m) times 2 or 4 writes.
// R06: default almost-full offset is 8, or 128 with strap high.
// R07: discrete almost-full asserts two cycles after the threshold write.
// R08: discrete almost-full releases after a read, two cycles total.
// R09: almost-full bus bits follow the same two cycle pipeline.
// R10: almost-empty high after n+2 writes (36/36), n+1 narrow out, scaled.
// R11: write-only queue: almost-empty bus high after n+1 writes, scaled.
// R12: default almost-empty offset is 8, or 128 with strap high.
// R13: discrete almost-empty asserts two cycles after the boundary read.
// R14: discrete almost-empty releases after a write, two cycles total.
// R15: almost-empty bus bits assert and release through two stages.
// R16: packet-ready changes only on rising clock edges.
// R17: packet-ready low once an end marker follows a start marker.
// R18: packet-ready falls two cycles after the end marker write.
// R19: packet-ready high when the last start marker is read out.
// R20: packet-ready rises two cycles after that read.
// R21: new read queue shows its almost-empty status on second edge.
// R22: each queue holds its own almost-empty offset, zero to depth.
// R23: status of every queue is tracked, selected or not.
// R24: every status flag is active low; the packet-ready bits of the status register read active high.
module queue_flag_logic
   import qflag_pkg::*;
#(
   parameter int DEPTH = 1024
)(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        default_offset_select,
   input  wire wr_port_s    wr_port,
   input  wire rd_port_s    rd_port,
   output logic             queue_full_n,
   output logic             almost_full_n,
   output logic             almost_empty_n,
   output logic             packet_ready_n,
   output logic      [7:0]  almost_full_bus,
   output logic      [7:0]  almost_empty_bus
);

   localparam int NQ   = `NUM_QUEUES;
   localparam int BQ   = `BUS_QUEUES;
   localparam int OW   = $clog2(DEPTH + 1);
   localparam int CW   = $clog2((DEPTH + 2) * 4 + 1);
   localparam int PKW  = $clog2(DEPTH + 1);

   ////////////////////////////////////////////////////////////////////////
   // declarations

   init_e             init_ff;
   logic              dflt_s1_ff;
   logic              dflt_s2_ff;
   logic              dflt_cap_ff;
   logic [2:0]        mode_ff;
   bw_mode_e          mode;
   logic [2:0]        wstep;
   logic [2:0]        rstep;
   logic              run;

   qid_t              wr_sel_ff;
   qid_t              nxt_wr_sel;
   qid_t              rd_sel_ff;
   qid_t              rd_sel_d_ff;
   logic              wr_go;
   logic              rd_go;

   logic [CW-1:0]     occ_ff     [NQ];
   logic [CW-1:0]     nxt_occ    [NQ];
   logic [PKW-1:0]    pk_cnt_ff  [NQ];
   logic [OW-1:0]     af_off_ff  [NQ];
   logic [OW-1:0]     ae_off_ff  [NQ];
   logic              same_ff    [NQ];
   logic              open_ff    [NQ];
   logic [NQ-1:0]     full_now;
   logic [NQ-1:0]     nxt_full;
   logic [NQ-1:0]     af_raw_n;
   logic [NQ-1:0]     ae_raw_n;
   logic [NQ-1:0]     rdy_raw_n;
   logic [NQ-1:0]     pk_inc;
   logic [NQ-1:0]     pk_dec;
   logic [NQ-1:0]     af_st_n_ff;
   logic [NQ-1:0]     ae_st_n_ff;
   logic [NQ-1:0]     rdy_st_n_ff;

   logic              queue_full_n_ff;
   logic              almost_full_n_ff;
   logic              almost_empty_n_ff;
   logic              packet_ready_n_ff;
   logic [7:0]        almost_full_bus_ff;
   logic [7:0]        almost_empty_bus_ff;

   logic              setup;
   logic              wr_acc;
   logic              addr_ok;
   logic [31:0]       rd_word;
   logic [OW-1:0]     wr_off;
   logic [OW-1:0]     dflt_off;
   qid_t              aq;
   logic [31:0]       prdata_ff;
   logic              pready_ff;
   logic              pslverr_ff;

   assign prdata           = prdata_ff;
   assign pready           = pready_ff;
   assign pslverr          = pslverr_ff;
   assign queue_full_n     = queue_full_n_ff;
   assign almost_full_n    = almost_full_n_ff;
   assign almost_empty_n   = almost_empty_n_ff;
   assign packet_ready_n   = packet_ready_n_ff;
   assign almost_full_bus  = almost_full_bus_ff;
   assign almost_empty_bus = almost_empty_bus_ff;

   ////////////////////////////////////////////////////////////////////////
   // strap capture and start-up: the strap is synchronised before the
   // default offsets are loaded, so ports stay refused until INIT_RUN

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dflt_s1_ff <= 1'b0;
         dflt_s2_ff <= 1'b0;
      end else begin
         dflt_s1_ff <= default_offset_select;
         dflt_s2_ff <= dflt_s1_ff;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         init_ff <= INIT_SYNC0;
      end else begin
         unique case (init_ff)
            INIT_SYNC0: init_ff <= INIT_SYNC1;
            INIT_SYNC1: init_ff <= INIT_LOAD;
            INIT_LOAD:  init_ff <= INIT_RUN;
            INIT_RUN:   init_ff <= INIT_RUN;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dflt_cap_ff <= 1'b0;
      end else if (init_ff == INIT_LOAD) begin
         dflt_cap_ff <= dflt_s2_ff;
      end
   end

   assign run      = (init_ff == INIT_RUN);
   assign dflt_off = dflt_s2_ff ? OW'(`DEF_OFF_HI) : OW'(`DEF_OFF_LO);

   ////////////////////////////////////////////////////////////////////////
   // bus width mode: occupancy counts quarter words, so one 36-bit word
   // is four units whatever the port widths

   always_comb begin
      case (mode_ff)
         3'h1:    mode = BW_36_18;
         3'h2:    mode = BW_36_9;
         3'h3:    mode = BW_18_36;
         3'h4:    mode = BW_9_36;
         default: mode = BW_36_36;
      endcase
   end

   always_comb begin
      wstep = `STEP_36;
      rstep = `STEP_36;
      unique case (mode)
         BW_36_18: rstep = `STEP_18;
         BW_36_9:  rstep = `STEP_9;
         BW_18_36: wstep = `STEP_18;
         BW_9_36:  wstep = `STEP_9;
         BW_36_36: wstep = `STEP_36;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // queue selection; a write or read in the load cycle uses the old queue

   assign nxt_wr_sel = wr_port.load ? wr_port.queue : wr_sel_ff;
   assign wr_go = run && wr_port.en && !full_now[wr_sel_ff];
   assign rd_go = run && rd_port.en
                  && (occ_ff[rd_sel_ff] >= CW'(rstep));

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wr_sel_ff   <= 4'h0;
         rd_sel_ff   <= 4'h0;
         rd_sel_d_ff <= 4'h0;
      end else begin
         wr_sel_ff   <= nxt_wr_sel;
         rd_sel_d_ff <= rd_sel_ff;
         if (rd_port.load)
            rd_sel_ff <= rd_port.read_queue_select_bus;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // per-queue tracking, selected or not [R23]

   for (genvar q = 0; q < NQ; q++) begin : g_queue
      logic          wr_hit;
      logic          rd_hit;
      logic          slot;
      logic          af_slot;
      logic [CW-1:0] full_t;
      logic [CW-1:0] af_t;
      logic [CW-1:0] ae_t;

      assign wr_hit = wr_go && (wr_sel_ff == qid_t'(q));
      assign rd_hit = rd_go && (rd_sel_ff == qid_t'(q));
      // the output register adds one word when both ports shared the
      // queue from its first word, except on narrow output modes
      assign slot    = same_ff[q] && (mode != BW_36_18)
                       && (mode != BW_36_9);
      assign af_slot = (same_ff[q] && (mode == BW_36_36))
                       || (mode == BW_18_36) || (mode == BW_9_36);
      assign full_t = CW'((DEPTH + int'(slot)) << `QUARTER_SHIFT);
      assign af_t   = CW'((DEPTH + int'(af_slot) - int'(af_off_ff[q]))
                          << `QUARTER_SHIFT); // [R03] [R04] [R05]
      assign ae_t   = CW'((int'(ae_off_ff[q]) + 1 + int'(slot))
                          << `QUARTER_SHIFT); // [R10] [R11] [R22]

      assign nxt_occ[q]   = occ_ff[q] + (wr_hit ? CW'(wstep) : '0)
                            - (rd_hit ? CW'(rstep) : '0);
      assign full_now[q]  = occ_ff[q] >= full_t;
      assign nxt_full[q]  = nxt_occ[q] >= full_t;
      assign af_raw_n[q]  = !(occ_ff[q] >= af_t);      // [R24]
      assign ae_raw_n[q]  = occ_ff[q] >= ae_t;         // [R24]
      assign pk_inc[q]    = wr_hit && wr_port.tx_end_marker
                            && (open_ff[q] || wr_port.tx_start_marker);
      assign pk_dec[q]    = rd_hit && rd_port.rx_start_marker
                            && (pk_cnt_ff[q] != '0);
      assign rdy_raw_n[q] = (pk_cnt_ff[q] == '0);     // [R17] [R19]

      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            occ_ff[q]    <= '0;
            same_ff[q]   <= 1'b0;
            open_ff[q]   <= 1'b0;
            pk_cnt_ff[q] <= '0;
         end else begin
            occ_ff[q] <= nxt_occ[q];
            if (wr_hit && (occ_ff[q] == '0))
               same_ff[q] <= (rd_sel_ff == qid_t'(q));
            if (wr_hit && wr_port.tx_end_marker)
               open_ff[q] <= 1'b0;
            else if (wr_hit && wr_port.tx_start_marker)
               open_ff[q] <= 1'b1;
            if (pk_inc[q] && !pk_dec[q])
               pk_cnt_ff[q] <= pk_cnt_ff[q] + PKW'(1);   // [R17]
            else if (pk_dec[q] && !pk_inc[q])
               pk_cnt_ff[q] <= pk_cnt_ff[q] - PKW'(1);   // [R19]
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // flag pipeline: internal status stage, then output stage

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         af_st_n_ff  <= '1;
         ae_st_n_ff  <= '0;
         rdy_st_n_ff <= '1;
      end else begin
         af_st_n_ff  <= af_raw_n;                     // [R07] [R08]
         ae_st_n_ff  <= ae_raw_n;                     // [R13] [R14]
         rdy_st_n_ff <= rdy_raw_n;                    // [R16]
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         queue_full_n_ff     <= 1'b1;
         almost_full_n_ff    <= 1'b1;
         almost_empty_n_ff   <= 1'b0;
         packet_ready_n_ff   <= 1'b1;
         almost_full_bus_ff  <= 8'hFF;
         almost_empty_bus_ff <= 8'h00;
      end else begin
         // next occupancy, so full shows at the filling edge itself
         queue_full_n_ff     <= !nxt_full[nxt_wr_sel];    // [R01] [R02]
         almost_full_n_ff    <= af_st_n_ff[wr_sel_ff];    // [R07] [R08]
         almost_empty_n_ff   <= ae_st_n_ff[rd_sel_d_ff];  // [R13] [R21]
         packet_ready_n_ff   <= rdy_st_n_ff[rd_sel_d_ff]; // [R18] [R20]
         almost_full_bus_ff  <= af_st_n_ff[BQ-1:0];       // [R09]
         almost_empty_bus_ff <= ae_st_n_ff[BQ-1:0];       // [R15]
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // APB slave: zero wait, data and error latched in the setup cycle

   assign setup  = psel && !penable;
   assign wr_acc = psel && penable && pready_ff && pwrite && !pslverr_ff;
   assign aq     = qid_t'(paddr[5:2]);
   assign wr_off = (pwdata > 32'(DEPTH)) ? OW'(DEPTH) : pwdata[OW-1:0];

   always_comb begin
      rd_word = 32'h0000_0000;
      addr_ok = (paddr[1:0] == 2'h0);
      unique case (paddr[7:6])
         `GRP_CTRL: begin
            if (paddr == `REG_CTRL) begin
               rd_word[`CTRL_MODE_MSB:0] = mode_ff;
            end else if (paddr == `REG_STATUS) begin
               rd_word[NQ-1:0]           = ~rdy_raw_n;
               rd_word[`STAT_DFLT_BIT]   = dflt_cap_ff;
               rd_word[`STAT_RUN_BIT]    = run;
            end else begin
               addr_ok = 1'b0;
            end
         end
         `GRP_AF_OFF: rd_word[OW-1:0] = af_off_ff[aq];
         `GRP_AE_OFF: rd_word[OW-1:0] = ae_off_ff[aq];
         `GRP_OCC: begin
            rd_word[CW-1:0] = occ_ff[aq];
            if (pwrite)
               addr_ok = 1'b0;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff  <= 32'h0000_0000;
      end else begin
         pready_ff <= setup;
         if (setup) begin
            pslverr_ff <= !addr_ok;
            prdata_ff  <= pwrite ? 32'h0000_0000 : rd_word;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_ff <= `CTRL_RESET;
      end else if (wr_acc && (paddr == `REG_CTRL)) begin
         mode_ff <= pwdata[`CTRL_MODE_MSB:0];
      end
   end

   // the strap load overrides a bus write landing in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < NQ; i++) begin
            af_off_ff[i] <= '0;
            ae_off_ff[i] <= '0;
         end
      end else if (init_ff == INIT_LOAD) begin
         for (int i = 0; i < NQ; i++) begin
            af_off_ff[i] <= dflt_off;                  // [R06]
            ae_off_ff[i] <= dflt_off;                  // [R12]
         end
      end else if (wr_acc && (paddr[7:6] == `GRP_AF_OFF)) begin
         af_off_ff[aq] <= wr_off;
      end else if (wr_acc && (paddr[7:6] == `GRP_AE_OFF)) begin
         ae_off_ff[aq] <= wr_off;                      // [R22]
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // assertions

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   chk_full_direct: assert property ( // [R01]
      wr_go && !wr_port.load && nxt_full[wr_sel_ff] |=> !queue_full_n_ff)
      else $error("full flag missed the filling write");

   chk_full_release: assert property ( // [R02]
      !queue_full_n_ff && !wr_port.load && !nxt_full[wr_sel_ff]
      |=> queue_full_n_ff)
      else $error("full flag did not release after space freed");

   chk_af_bound: assert property ( // [R03]
      mode == BW_36_36 && same_ff[0]
      && occ_ff[0] == CW'((DEPTH + 1 - int'(af_off_ff[0])) * 4)
      |-> !af_raw_n[0] ##1 !af_st_n_ff[0])
      else $error("almost full boundary wrong");

   chk_af_delay: assert property ( // [R07]
      $stable(wr_sel_ff) |=> almost_full_n_ff
      == 1'($past(af_raw_n, 2) >> $past(wr_sel_ff, 2)))
      else $error("almost full not two cycles after cause");

   chk_af_bus: assert property ( // [R09]
      almost_full_bus_ff == 8'($past(af_raw_n, 2)))
      else $error("almost full bus latency wrong");

   chk_ae_bound: assert property ( // [R10]
      mode == BW_36_36 && same_ff[0]
      && occ_ff[0] == CW'((int'(ae_off_ff[0]) + 1) * 4)
      |-> !ae_raw_n[0])
      else $error("almost empty released one write early");

   chk_ae_delay: assert property ( // [R13]
      $stable(rd_sel_d_ff) |=> almost_empty_n_ff
      == 1'($past(ae_raw_n, 2) >> $past(rd_sel_d_ff, 2)))
      else $error("almost empty not two cycles after cause");

   chk_ae_bus: assert property ( // [R15]
      almost_empty_bus_ff == 8'($past(ae_raw_n, 2)))
      else $error("almost empty bus latency wrong");

   chk_ready_set: assert property ( // [R17]
      pk_inc[wr_sel_ff] |=> !rdy_raw_n[$past(wr_sel_ff)])
      else $error("packet not counted on end marker");

   chk_ready_clear: assert property ( // [R19]
      pk_dec[rd_sel_ff] && !pk_inc[rd_sel_ff]
      && pk_cnt_ff[rd_sel_ff] == PKW'(1)
      |=> rdy_raw_n[$past(rd_sel_ff)])
      else $error("packet ready kept after last start read");

   chk_ready_delay: assert property ( // [R18]
      $stable(rd_sel_d_ff) |=> packet_ready_n_ff
      == 1'($past(rdy_raw_n, 2) >> $past(rd_sel_d_ff, 2)))
      else $error("packet ready not two cycles after cause");

   chk_read_switch: assert property ( // [R21]
      $past(rd_port.load, 3) |-> almost_empty_n_ff
      == 1'($past(ae_st_n_ff) >> $past(rd_port.read_queue_select_bus, 3)))
      else $error("almost empty not switched on second edge");

   chk_dflt_offset: assert property ( // [R06]
      init_ff == INIT_LOAD |=> af_off_ff[0] == ae_off_ff[NQ-1]
      && af_off_ff[0] == (dflt_cap_ff ? OW'(`DEF_OFF_HI)
                                      : OW'(`DEF_OFF_LO)))
      else $error("default offsets not loaded from strap");

   cov_full: cover property (wr_go ##1 !queue_full_n_ff);
   cov_ready: cover property ($fell(packet_ready_n_ff));
   cov_switch: cover property (rd_port.load ##2 $changed(almost_empty_n));
   cov_af: cover property ($fell(almost_full_n_ff));

endmodule

// ==== sim/multi_queue_flag_boundary_logic_tb_top.sv ====
// self-checking bench for the queue flag logic
`timescale 1ns/10ps
module multi_queue_flag_boundary_logic_tb_top
   import qflag_pkg::*;
;
   localparam int DEPTH = 256;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic        default_offset_select, queue_full_n, almost_full_n;
   logic        almost_empty_n, packet_ready_n;
   logic [7:0]  paddr, almost_full_bus, almost_empty_bus;
   logic [31:0] pwdata, prdata;
   wr_port_s    wr_port;
   rd_port_s    rd_port;
   int          num_errors = 0;
   int          checks = 0;
   int          bq = 0;

   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end

   queue_flag_logic #(.DEPTH(DEPTH)) dut (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .default_offset_select, .wr_port, .rd_port,
      .queue_full_n, .almost_full_n, .almost_empty_n, .packet_ready_n,
      .almost_full_bus, .almost_empty_bus
   );
   queue_port_model far (.pclk, .wr_port, .rd_port);

   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [31:0] seen, exp);
      checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic close_out();
      if (num_errors == 0 && checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // full, almost full, almost empty, packet ready, bus bits of queue bq
   function automatic logic [31:0] flags();
      return {26'h0, queue_full_n, almost_full_n, almost_empty_n,
              packet_ready_n, almost_full_bus[bq], almost_empty_bus[bq]};
   endfunction

   // flags one and two edges after the last port operation
   task automatic op_chk(input logic [5:0] e1, e2);
      @(posedge pclk);
      #1 chk("flags at +1", flags(), {26'h0, e1});
      @(posedge pclk);
      #1 chk("flags at +2", flags(), {26'h0, e2});
   endtask

   task automatic acc(input logic w, input logic [7:0] a,
                      input logic [31:0] d, exp, input logic eerr);
      logic [31:0] rd;
      logic        err;
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      chk("pslverr", {31'h0, err}, {31'h0, eerr});
      if (!w) chk("prdata", rd, exp);
   endtask

   // strap must stay put until the defaults are loaded
   task automatic do_reset(input logic s);
      presetn <= 1'b0;
      default_offset_select <= s;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      repeat (4) @(posedge pclk);
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20000) @(posedge pclk);
      num_errors++;
      close_out();
   end

   initial begin
      presetn = 1'b0;
      default_offset_select = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      do_reset(1'b0);
      chk("flags", flags(), 32'h36);
      chk("buses", {16'h0, almost_full_bus, almost_empty_bus},
          32'hFF00);
      acc(1'b0, 8'h04, 32'h0, 32'h20000, 1'b0);
      acc(1'b0, 8'h40, 32'h0, 32'h8, 1'b0);
      acc(1'b0, 8'h84, 32'h0, 32'h8, 1'b0);
      acc(1'b0, 8'h08, 32'h0, 32'h0, 1'b1);
      acc(1'b1, 8'hC0, 32'h5, 32'h0, 1'b1);
      acc(1'b1, 8'h40, 32'h3, 32'h0, 1'b0);
      acc(1'b1, 8'h80, 32'h2, 32'h0, 1'b0);
      acc(1'b1, 8'h88, 32'h1FF, 32'h0, 1'b0);
      acc(1'b0, 8'h88, 32'h0, 32'h100, 1'b0);
      acc(1'b0, 8'h80, 32'h0, 32'h2, 1'b0);
      // queue 0, both ports on it, 36/36, m = 3, n = 2
      far.sel(4'h0, 4'h0);
      far.push(3, 1'b0, 1'b0);
      far.push(1, 1'b0, 1'b0);
      op_chk(6'h36, 6'h3F);
      far.push(249, 1'b0, 1'b0);
      far.push(1, 1'b0, 1'b0);
      op_chk(6'h3F, 6'h2D);
      far.push(2, 1'b0, 1'b0);
      far.push(1, 1'b0, 1'b0);
      op_chk(6'h0D, 6'h0D);
      // a write while full is dropped
      far.push(1, 1'b0, 1'b0);
      acc(1'b0, 8'hC0, 32'h0, 32'h404, 1'b0);
      far.pop(1, 1'b0);
      op_chk(6'h2D, 6'h2D);
      far.pop(2, 1'b0);
      far.pop(1, 1'b0);
      op_chk(6'h2D, 6'h3F);
      far.pop(249, 1'b0);
      far.pop(1, 1'b0);
      op_chk(6'h3F, 6'h36);
      // an end marker with no start before it makes no packet
      far.push(1, 1'b0, 1'b1);
      op_chk(6'h36, 6'h3F);
      far.push(1, 1'b1, 1'b0);
      op_chk(6'h3F, 6'h3F);
      far.push(1, 1'b0, 1'b1);
      op_chk(6'h3F, 6'h3B);
      acc(1'b0, 8'h04, 32'h0, 32'h20001, 1'b0);
      far.pop(1, 1'b1);
      op_chk(6'h3B, 6'h3F);
      // queue 1, write port only, 18-bit input, defaults m = n = 8
      acc(1'b1, 8'h00, 32'h3, 32'h0, 1'b0);
      far.sel(4'h1, 4'h0);
      bq = 1;
      far.push(17, 1'b0, 1'b0);
      far.push(1, 1'b0, 1'b0);
      op_chk(6'h3E, 6'h3F);
      far.push(479, 1'b0, 1'b0);
      far.push(1, 1'b0, 1'b0);
      op_chk(6'h3F, 6'h2D);
      acc(1'b0, 8'hC4, 32'h0, 32'h3E4, 1'b0);
      // reset in mid-run with the strap high
      do_reset(1'b1);
      acc(1'b0, 8'h04, 32'h0, 32'h30000, 1'b0);
      acc(1'b0, 8'h44, 32'h0, 32'h80, 1'b0);
      acc(1'b0, 8'hBC, 32'h0, 32'h80, 1'b0);
      // queue 2, both ports on it, 36/18, n = 1
      acc(1'b1, 8'h00, 32'h1, 32'h0, 1'b0);
      acc(1'b1, 8'h88, 32'h1, 32'h0, 1'b0);
      far.sel(4'h2, 4'h2);
      bq = 2;
      far.push(1, 1'b0, 1'b0);
      far.push(1, 1'b0, 1'b0);
      op_chk(6'h36, 6'h3F);
      far.pop(1, 1'b0);
      op_chk(6'h3F, 6'h36);
      // queue 3, write port only, 9-bit input, n = 1
      acc(1'b1, 8'h00, 32'h4, 32'h0, 1'b0);
      acc(1'b1, 8'h8C, 32'h1, 32'h0, 1'b0);
      far.sel(4'h3, 4'h2);
      bq = 3;
      far.push(7, 1'b0, 1'b0);
      far.push(1, 1'b0, 1'b0);
      op_chk(6'h36, 6'h37);
      close_out();
   end
endmodule

// ==== sim/queue_port_model.sv ====
// far-side model that writes and reads queue words through both ports
`timescale 1ns/10ps
module queue_port_model
   import qflag_pkg::*;
(
   input  wire logic pclk,
   output wr_port_s  wr_port,
   output rd_port_s  rd_port
);
   initial begin
      wr_port = '0;
      rd_port = '0;
   end
   ////////////////////////////////////////////////////////////////////////
   // every task starts and ends just after a rising edge; the release
   // edge leaves one idle cycle between two calls
   task automatic push(input int n, input logic s, input logic e);
      for (int i = 0; i < n; i++) begin
         @(posedge pclk);
         wr_port <= {1'b0, 4'h0, 1'b1, s, e};
      end
      @(posedge pclk);
      wr_port <= '0;
   endtask
   task automatic pop(input int n, input logic s);
      for (int i = 0; i < n; i++) begin
         @(posedge pclk);
         rd_port <= {1'b0, 4'h0, 1'b1, s};
      end
      @(posedge pclk);
      rd_port <= '0;
   endtask
   task automatic sel(input qid_t wq, input qid_t rq);
      @(posedge pclk);
      wr_port <= {1'b1, wq, 3'h0};
      rd_port <= {1'b1, rq, 2'h0};
      @(posedge pclk);
      wr_port <= '0;
      rd_port <= '0;
   endtask
endmodule
